//--- logic/sdf_frame.sv
// serial input frame receiver and converter register
`timescale 1ns/1ps
module sdf_frame
    import sdf_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic din,
    output logic [CODE_BITS-1:0] analog_output_code,
    output logic [1:0] power_down_mode,
    output logic power_down,
    output logic update_pulse,
    output logic abort_pulse
);
    logic sclk_s, sync_n_s, din_s;
    logic sclk_prev_q, sync_prev_q;
    sdf_state_t state_q, state_d;
    logic [FRAME_BITS-1:0] shift_q, shift_d;
    logic [4:0] cnt_q, cnt_d;
    logic [CODE_BITS-1:0] code_q;
    logic [1:0] pd_q;
    logic upd_q, abt_q;

    // sclk idles high between frames, sync_n idles high
    sdf_sync2 #(.RESET_VAL(1'b1)) u_sclk (.mclk(mclk), .reset_n(reset_n), .pin(sclk), .sync(sclk_s));
    sdf_sync2 #(.RESET_VAL(1'b1)) u_sync (.mclk(mclk), .reset_n(reset_n), .pin(sync_n),
        .sync(sync_n_s));
    sdf_sync2 #(.RESET_VAL(1'b0)) u_din (.mclk(mclk), .reset_n(reset_n), .pin(din), .sync(din_s));

    // sampling the pins limits sclk to well under mclk/4; the 30 MHz pin rate needs a faster mclk
    wire sclk_fall = sclk_prev_q & ~sclk_s;
    wire sync_fall = sync_prev_q & ~sync_n_s;
    wire sync_rise = ~sync_prev_q & sync_n_s;
    wire frame_en = ~sync_n_s;
    wire take_bit = frame_en & sclk_fall & (state_q == SDF_SHIFT);
    wire last_bit = take_bit & (cnt_q == CNT_LAST);
    wire [FRAME_BITS-1:0] frame_word = {shift_q[FRAME_BITS-2:0], din_s};
    wire early_rise = sync_rise & (state_q == SDF_SHIFT);

    // the layout constants must place one whole code and the mode bits inside the frame
    if (CODE_MSB - CODE_LSB + 1 != CODE_BITS) begin
        $error("code field width differs from the code width");
    end
    if (PD_MSB - PD_LSB + 1 != 2) begin
        $error("power-down field is not two bits wide");
    end
    if (PD_MSB >= FRAME_BITS || CODE_MSB >= FRAME_BITS) begin
        $error("frame layout reaches past the frame");
    end
    // the five-bit counter must end on the last bit of the frame
    if (int'(CNT_LAST) != FRAME_BITS - 1) begin
        $error("last count does not match the frame length");
    end

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        case (state_q)
            SDF_IDLE: begin
                if (sync_fall) begin
                    state_d = SDF_SHIFT;
                    cnt_d = CNT_RESET;
                    shift_d = '0;
                end
            end
            SDF_SHIFT: begin
                if (sync_n_s) begin
                    state_d = SDF_IDLE;
                end else if (take_bit) begin
                    shift_d = frame_word;
                    cnt_d = cnt_q + 5'h01;
                    if (last_bit) begin
                        state_d = SDF_DONE;
                    end
                end
            end
            SDF_DONE: begin
                // further clocks in the same frame are ignored until sync rises
                if (sync_n_s) begin
                    state_d = SDF_IDLE;
                end
            end
            default: begin
                state_d = SDF_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev_q <= 1'b1;
            sync_prev_q <= 1'b1;
            state_q <= SDF_IDLE;
            shift_q <= '0;
            cnt_q <= CNT_RESET;
        end else begin
            sclk_prev_q <= sclk_s;
            sync_prev_q <= sync_n_s;
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            code_q <= CODE_RESET;
            pd_q <= PD_RESET;
        end else if (last_bit) begin
            code_q <= frame_word[CODE_MSB:CODE_LSB];
            pd_q <= frame_word[PD_MSB:PD_LSB];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            upd_q <= 1'b0;
            abt_q <= 1'b0;
        end else begin
            upd_q <= last_bit;
            abt_q <= early_rise;
        end
    end

    assign analog_output_code = code_q;
    assign power_down_mode = pd_q;
    assign power_down = (pd_q != PD_NORMAL);
    assign update_pulse = upd_q;
    assign abort_pulse = abt_q;
endmodule

//--- logic/sdf_pkg.sv
// constants and types of the serial converter input frame
// Behaviour
// - after frame sync falls, one data bit is taken on each of the first sixteen falling serial clock edges into a 16-bit shift register, valid at that edge.
// - the shift register accepts bits only while the active-low frame sync is low.
// - on the sixteenth falling serial clock edge of a frame the code is moved to the converter register.
// - frame sync rising before the sixteenth edge aborts the frame and leaves the converter register unchanged.
// - after reset the converter register holds zero until the first complete frame arrives.
// - the converter code is 8 bits wide and the output is proportional to it against the supply.
package sdf_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CODE_BITS = 8;
    // frame layout: two don't-care bits, two power-down bits, code, four don't-care bits
    localparam int PD_MSB = 13;
    localparam int PD_LSB = 12;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 4;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [1:0] PD_RESET = 2'h0;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [4:0] CNT_RESET = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h0f;
    localparam int SCLK_MAX_MHZ = 30;
    localparam int MCLK_MHZ = 10;
    typedef enum logic [2:0] {
        SDF_IDLE = 3'b001,
        SDF_SHIFT = 3'b010,
        SDF_DONE = 3'b100
    } sdf_state_t;
endpackage

//--- logic/sdf_sync2.sv
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
module sdf_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pin,
    output logic sync
);
    logic meta_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            sync <= RESET_VAL;
        end else begin
            meta_q <= pin;
            sync <= meta_q;
        end
    end
endmodule

//--- test/sdf_host.sv
// host model driving three-wire write frames
`timescale 1ns/1ps
module sdf_host (
    input wire logic mclk,
    output logic sclk,
    output logic sync_n,
    output logic din
);
    initial begin
        sclk = 1'b1;
        sync_n = 1'b1;
        din = 1'b0;
    end
    // sclk stands high between frames; 8 mclk a bit, far below 30 MHz
    task automatic xfer(input logic [15:0] w, input int n, input logic sel);
        int i;
        @(negedge mclk);
        sync_n = ~sel;
        repeat (4) @(negedge mclk);
        for (i = 15; i > 15 - n; i--) begin
            din = w[i];
            repeat (4) @(negedge mclk);
            sclk = 1'b0;
            repeat (4) @(negedge mclk);
            sclk = 1'b1;
        end
        repeat (4) @(negedge mclk);
        sync_n = 1'b1; // early rise when n < 16
        din = ~din;
        repeat (8) @(negedge mclk);
    endtask
endmodule

//--- test/sdf_frame_assertions.sv
// port assertions of the serial frame receiver
`timescale 1ns/1ps
module sdf_frame_chk
    import sdf_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sync_n,
    input wire logic [CODE_BITS-1:0] analog_output_code,
    input wire logic [1:0] power_down_mode,
    input wire logic power_down,
    input wire logic update_pulse,
    input wire logic abort_pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_reset_zero: assert property ($rose(reset_n) |-> analog_output_code == 8'h00)
        else $error("code not zero after reset");
    chk_update_once: assert property (update_pulse |=> !update_pulse)
        else $error("update pulse too long");
    chk_code_update: assert property ($changed(analog_output_code) |-> update_pulse)
        else $error("code changed without update");
    chk_abort_keeps: assert property (abort_pulse |-> $stable(analog_output_code))
        else $error("abort changed code");
    chk_idle_quiet: assert property (sync_n [*8] |-> !(update_pulse || abort_pulse))
        else $error("activity while deselected");
    chk_update_cause: assert property (update_pulse |-> !$past(sync_n, 5))
        else $error("update without frame");
    chk_pd_flag: assert property (power_down == (power_down_mode != 2'h0))
        else $error("power down flag wrong");
endmodule
bind sdf_frame sdf_frame_chk chk_u (.mclk(mclk), .reset_n(reset_n), .sync_n(sync_n),
    .analog_output_code(analog_output_code), .power_down_mode(power_down_mode),
    .power_down(power_down), .update_pulse(update_pulse), .abort_pulse(abort_pulse));

//--- test/test_sdf_frame.sv
// self-checking bench of the serial frame receiver
`timescale 1ns/1ps
module test_sdf_frame import sdf_pkg::*;;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    wire sclk, sync_n, din, pd, upd, abt;
    wire [7:0] code;
    wire [1:0] mode;
    int errors = 0;
    int total_checks = 0;
    int upd_seen = 0;
    int abt_seen = 0;
    sdf_host host_u (.mclk(mclk), .sclk(sclk), .sync_n(sync_n), .din(din));
    sdf_frame dut_u (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .sync_n(sync_n), .din(din),
        .analog_output_code(code), .power_down_mode(mode), .power_down(pd),
        .update_pulse(upd), .abort_pulse(abt));
    initial begin
        forever #50 mclk = ~mclk;
    end
    // pulses are counted at the falling edge, half a cycle after they are launched
    always @(negedge mclk) begin
        if (upd === 1'b1) begin
            upd_seen++;
        end
        if (abt === 1'b1) begin
            abt_seen++;
        end
    end
    task automatic check(input string s, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // every power-down mode, each with its own code
    task automatic t_modes;
        int u0;
        int a0;
        for (int m = 0; m < 4; m++) begin
            u0 = upd_seen;
            a0 = abt_seen;
            host_u.xfer({2'h3, 2'(m), 8'h5a + 8'(m), 4'h9}, 16, 1'b1);
            check("code", code, 8'h5a + 8'(m));
            check("mode", {6'h0, mode}, 8'(m));
            check("pd", {7'h0, pd}, {7'h0, m != 0});
            check("update", 8'(upd_seen - u0), 8'h01);
            check("no abort", 8'(abt_seen - a0), 8'h00);
        end
        $display("modes done");
    endtask
    // fifteen bits then sync rise, then clocks while deselected
    task automatic t_refuse;
        int u0;
        int a0;
        u0 = upd_seen;
        a0 = abt_seen;
        host_u.xfer(16'h0ff0, 15, 1'b1);
        check("abort", code, 8'h5d);
        check("abort pulse", 8'(abt_seen - a0), 8'h01);
        host_u.xfer(16'h0a50, 16, 1'b0);
        check("idle", code, 8'h5d);
        check("no update", 8'(upd_seen - u0), 8'h00);
        check("idle abort", 8'(abt_seen - a0), 8'h01);
        $display("refusals done");
    endtask
    // reset in mid-run; aborted and deselected frames leave zero until a full frame
    task automatic t_restart;
        @(negedge mclk);
        reset_n = 1'b0;
        @(negedge mclk);
        check("reset now", code, CODE_RESET);
        check("mode reset", {6'h0, mode}, {6'h0, PD_RESET});
        repeat (9) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        host_u.xfer(16'h3a70, 15, 1'b1);
        check("still zero", code, CODE_RESET);
        host_u.xfer(16'h3a70, 16, 1'b0);
        check("zero idle", code, CODE_RESET);
        host_u.xfer(16'h0a70, 16, 1'b1);
        check("first write", code, 8'ha7);
        check("first mode", {6'h0, mode}, 8'h00);
        $display("restart done");
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        check("reset", code, CODE_RESET);
        t_modes();
        t_refuse();
        t_restart();
        tally_and_finish();
    end
endmodule
